// *** pkg/mdfa_map.vh ***
// mdfa_map.vh: offsets, bit positions, codes and timing counts for the
// file attachment control block; included by every rtl file of it.
`ifndef MDFA_MAP_VH
`define MDFA_MAP_VH

// bit n of a byte counts from the most significant end
`define MDFA_BIT(n)        (7-(n))

// apb register byte offsets
`define MDFA_OFF_FT        8'h00
`define MDFA_OFF_FC        8'h04
`define MDFA_OFF_MODSEL    8'h08
`define MDFA_OFF_ALTSRC    8'h0c
`define MDFA_OFF_ALUIN     8'h10
`define MDFA_OFF_IE        8'h14
`define MDFA_OFF_CMD       8'h18
`define MDFA_OFF_UPROG     8'h1c
`define MDFA_OFF_HEAD      8'h20

// reset values
`define MDFA_RST_FT        8'h00
`define MDFA_RST_FC        8'h00
`define MDFA_RST_MODSEL    4'h0
`define MDFA_RST_ALTSRC    4'h0
`define MDFA_RST_UPROG     12'h000
`define MDFA_RST_HEAD      8'h00

// attachment types
`define MDFA_TY_DISK       2'd0
`define MDFA_TY_STRIP      2'd1
`define MDFA_TY_LDISK      2'd2
`define MDFA_TY_DRUM       2'd3

// function tag values and alternate source codes
`define MDFA_FT_CONTROL    8'h00
`define MDFA_FT_SET_SEEK   8'h01
`define MDFA_ALT_ATTN      4'hc
`define MDFA_ALT_STATUS    4'hd
`define MDFA_ALT_OLDADDR   4'he
`define MDFA_ALT_IFACE     4'hf

// command codes in the command register
`define MDFA_CMD_OTHER     2'd0
`define MDFA_CMD_SCAN      2'd1
`define MDFA_CMD_RESTORE   2'd2
`define MDFA_CMD_RECAL     2'd3

// head addresses that mark end of cylinder
`define MDFA_HEAD_EOC_A    8'h0a
`define MDFA_HEAD_EOC_B    8'h0b

// drum routine pages of control store
`define MDFA_UP_GATE_BIT   11
`define MDFA_UP_PAGE_LO    4'h8
`define MDFA_UP_PAGE_HI    4'ha

// timing, least times rounded up to whole cycles
`define MDFA_CLK_NS        25
`define MDFA_BYTE_NS       6400
`define MDFA_ERASE_BYTES   9
`define MDFA_LD_ERASE_US   40
`define MDFA_WSTAT_LEAD_US 5
`define MDFA_SEEK_TO_MS    600
`define MDFA_AUTO_RST_MS   800
`define MDFA_CEIL(ns)      (((ns)+`MDFA_CLK_NS-1)/`MDFA_CLK_NS)
`define MDFA_ERASE_CYC     `MDFA_CEIL(`MDFA_ERASE_BYTES*`MDFA_BYTE_NS)
`define MDFA_LD_ERASE_CYC  `MDFA_CEIL(`MDFA_LD_ERASE_US*1000)
`define MDFA_WSTAT_CYC     `MDFA_CEIL(`MDFA_WSTAT_LEAD_US*1000)
`define MDFA_SEEK_TO_CYC   `MDFA_CEIL(`MDFA_SEEK_TO_MS*1000000)
`define MDFA_AUTO_RST_CYC  `MDFA_CEIL(`MDFA_AUTO_RST_MS*1000000)
`define MDFA_TW            26

`endif

// *** rtl/mdfa_timer.v ***
// mdfa_timer.v: loadable down counter with a run level and a done pulse.
// assumes load and abort are synchronous to pclk.
`timescale 1ns/100ps
`include "mdfa_map.vh"
module mdfa_timer (
  // clock and reset
  input  wire                  pclk,
  input  wire                  presetn,
  // control
  input  wire                  load,
  input  wire                  abort,
  input  wire [`MDFA_TW-1:0]   val,
  // state
  output wire                  run,
  output wire                  done
);
  reg [`MDFA_TW-1:0] cnt_q;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= {`MDFA_TW{1'b0}};
    end else if (load) begin
      cnt_q <= val;
    end else if (abort) begin
      cnt_q <= {`MDFA_TW{1'b0}};
    end else if (cnt_q != {`MDFA_TW{1'b0}}) begin
      cnt_q <= cnt_q - {{(`MDFA_TW-1){1'b0}}, 1'b1};
    end
  end

  assign run  = (cnt_q != {`MDFA_TW{1'b0}});
  // reload on the last count restarts instead of expiring
  assign done = (cnt_q == {{(`MDFA_TW-1){1'b0}}, 1'b1}) & ~load & ~abort;
endmodule

// *** rtl/mdfa_unsafe.v ***
// mdfa_unsafe.v: latched unsafe condition built from four monitor lines.
// assumes mon is already chosen for the selected attachment type.
`timescale 1ns/100ps
`include "mdfa_map.vh"
module mdfa_unsafe (
  // clock and reset
  input  wire       pclk,
  input  wire       presetn,
  // monitoring
  input  wire       active,
  input  wire [3:0] mon,
  input  wire       clr,
  // result
  output reg        unsafe_q
);
  wire fail = active & ~(&mon);

  // latched for testing until the tag register is written; set wins
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      unsafe_q <= 1'b0;
    end else begin
      unsafe_q <= fail | (unsafe_q & ~clr);
    end
  end
endmodule

// *** rtl/mdfa_ctrl.v ***
// mdfa_ctrl.v: apb-mapped control and status of the file attachments.
// assumes device inputs are synchronous to pclk and apb is zero-wait.
// How it works
// - disk erase stays on through writing and nine byte times after
// - strip file raises write status five microseconds before write gate
// - large disk erase stays on at least forty microseconds after write
// - disk control bit six on tag zero returns access to cylinder zero
// - strip attention cleared by tag zero bit one on selected unit
// - source code thirteen gates file status onto unit input
// - online bits three five six all on unless a module is selected
// - strip unsafe from ready operative safety; drops gate head status
// - large disk unsafe watches access ready operative read write safety
// - drum online is file safe; unsafe shows as interface bit two low
// - disk seek incomplete on status bit seven after 600 ms
// - strip inoperative as status bit one low, bad address bit five low
// - disk end of cylinder on status bit five for heads ten, eleven
// - any attention ORed, bit seven disk else six, source fifteen
// - strip auto restore on status bit six after 800 ms idle
// - strip ready on status bit four after clutch and early index
// - drum selected by tag bit six with drum online
// - drum routines live at pages 8, 9, A reached by address bit 11
// - drum rejects file scan, restore and recalibrate do nothing
// - drum attention set by set seek complete, cleared on select
`timescale 1ns/100ps
`include "mdfa_map.vh"
module mdfa_ctrl #(
  parameter [`MDFA_TW-1:0] SEEK_TO_CYC  = `MDFA_SEEK_TO_CYC,
  parameter [`MDFA_TW-1:0] AUTO_RST_CYC = `MDFA_AUTO_RST_CYC
) (
  // clock and reset
  input  wire        pclk,
  input  wire        presetn,
  // apb slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  // module map
  input  wire [7:0]  mod_present,
  input  wire [15:0] mod_type,
  input  wire [7:0]  attention_in,
  // disk and large disk lines
  input  wire        dev_ready,
  input  wire        dev_online,
  input  wire        dev_unsafe,
  input  wire        seek_complete,
  input  wire [7:0]  cyl_position,
  input  wire        access_ready,
  input  wire        access_operative,
  input  wire        read_safe,
  input  wire        write_safe,
  // strip file lines
  input  wire        strip_online,
  input  wire        drive_ready,
  input  wire        drive_operative,
  input  wire        rw_safe,
  input  wire        invalid_addr,
  input  wire        clutch_picked,
  input  wire        early_index,
  // drum lines
  input  wire        drum_online,
  // device control outputs
  output reg         write_gate,
  output reg         erase_gate,
  output reg         write_status,
  output reg         read_gate,
  output reg         head_select,
  output reg         rtz_pulse,
  output reg         seek_start,
  output reg         strip_restore,
  output reg         drum_select,
  output reg         strip_select,
  output reg         uprog_gate_c
);
  reg  [7:0]  ft_q;
  reg  [7:0]  fc_q;
  reg  [3:0]  modsel_q;
  reg  [3:0]  altsrc_q;
  reg  [11:0] uprog_q;
  reg  [7:0]  head_q;
  reg  [2:0]  cmd_st_q;
  reg  [7:0]  attn_q;
  reg         seek_inc_q;
  reg         auto_rst_q;
  reg         strip_rdy_q;
  reg         wr_req_q;
  reg         lead_ok_q;
  reg  [7:0]  fs;
  reg  [7:0]  is_bits;
  reg  [7:0]  ie_bits;
  reg  [7:0]  alu_in;
  reg  [31:0] rd_d;
  reg         hit;
  reg  [3:0]  mon;
  wire        unsafe_q;
  wire        lead_run;
  wire        lead_done;
  wire        hold_run;
  wire        seek_done;
  wire        idle_done;

  // apb decode
  wire setup = psel & ~penable;
  wire wr    = psel & penable & pwrite;
  wire wr_ft = wr & (paddr == `MDFA_OFF_FT);
  wire wr_fc = wr & (paddr == `MDFA_OFF_FC);
  wire wr_ms = wr & (paddr == `MDFA_OFF_MODSEL);
  wire wr_cm = wr & (paddr == `MDFA_OFF_CMD);
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~hit;

  // selected module and its type
  wire [2:0] sel_mod = modsel_q[2:0];
  wire       sel_ok  = modsel_q[3] & mod_present[sel_mod];
  wire [1:0] sel_ty  = mod_type[{sel_mod, 1'b0} +: 2];
  wire ty_disk  = sel_ok & (sel_ty == `MDFA_TY_DISK);
  wire ty_strip = sel_ok & (sel_ty == `MDFA_TY_STRIP);
  wire ty_ldisk = sel_ok & (sel_ty == `MDFA_TY_LDISK);
  wire ty_drum  = sel_ok & (sel_ty == `MDFA_TY_DRUM);

  // control bits act only under the control tag
  wire       ctl_tag = (ft_q == `MDFA_FT_CONTROL);
  wire [7:0] fc_new  = pwdata[7:0];
  wire fc1_p = wr_fc & ctl_tag & fc_new[`MDFA_BIT(1)];
  wire fc2_p = wr_fc & ctl_tag & fc_new[`MDFA_BIT(2)];
  wire fc6_p = wr_fc & ctl_tag & fc_new[`MDFA_BIT(6)];
  wire set_seek_p = wr_ft & (pwdata[7:0] == `MDFA_FT_SET_SEEK) & ty_drum;
  wire strip_addr = ty_strip & (wr_ms | wr_fc | wr_ft);

  // write request: drum needs control bit zero only
  wire wr_req_d = ctl_tag & fc_q[`MDFA_BIT(0)] &
                  (ty_drum | fc_q[`MDFA_BIT(4)]);
  wire wr_fall  = wr_req_q & ~wr_req_d;
  wire wr_rise  = wr_req_d & ~wr_req_q;

  // erase hold after the write request drops
  localparam [`MDFA_TW-1:0] ERASE_CYC    = `MDFA_ERASE_CYC;
  localparam [`MDFA_TW-1:0] LD_ERASE_CYC = `MDFA_LD_ERASE_CYC;
  localparam [`MDFA_TW-1:0] WSTAT_CYC    = `MDFA_WSTAT_CYC;
  wire [`MDFA_TW-1:0] hold_val = ty_ldisk ?
       LD_ERASE_CYC : ERASE_CYC;

  mdfa_timer u_lead (
    .pclk    (pclk),
    .presetn (presetn),
    .load    (wr_rise & ty_strip),
    .abort   (~wr_req_d),
    .val     (WSTAT_CYC),
    .run     (lead_run),
    .done    (lead_done)
  );

  mdfa_timer u_hold (
    .pclk    (pclk),
    .presetn (presetn),
    .load    (wr_fall & (ty_disk | ty_ldisk)),
    .abort   (wr_req_d),
    .val     (hold_val),
    .run     (hold_run),
    .done    ()
  );

  // seek complete of the last seek still stands while seek_start is out
  mdfa_timer u_seek (
    .pclk    (pclk),
    .presetn (presetn),
    .load    (fc2_p & ty_disk),
    .abort   ((seek_complete & ~seek_start) | wr_ms),
    .val     (SEEK_TO_CYC),
    .run     (),
    .done    (seek_done)
  );

  mdfa_timer u_idle (
    .pclk    (pclk),
    .presetn (presetn),
    .load    (strip_addr),
    .abort   (1'b0),
    .val     (AUTO_RST_CYC),
    .run     (),
    .done    (idle_done)
  );

  // monitor lines differ between strip file and large disk
  always @* begin
    if (ty_ldisk) begin
      mon = {access_ready, access_operative, read_safe, write_safe};
    end else begin
      mon = {drive_ready, drive_operative, rw_safe, rw_safe};
    end
  end

  mdfa_unsafe u_unsafe (
    .pclk     (pclk),
    .presetn  (presetn),
    .active   (ty_strip | ty_ldisk),
    .mon      (mon),
    .clr      (wr_ft),
    .unsafe_q (unsafe_q)
  );

  // per-module attention latches; set wins over clear
  genvar i;
  generate
    for (i = 0; i < 8; i = i + 1) begin : g_attn
      wire [1:0] ty_i  = mod_type[2*i +: 2];
      wire       sel_i = sel_ok & (sel_mod == i);
      wire       drum_i  = (ty_i == `MDFA_TY_DRUM);
      wire       strip_i = (ty_i == `MDFA_TY_STRIP);
      wire set_i = drum_i ? (set_seek_p & sel_i) : attention_in[i];
      wire clr_i = strip_i ? (fc1_p & sel_i) :
                   drum_i  ? (wr_ms & (pwdata[2:0] == i)) :
                   1'b1;
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          attn_q[i] <= 1'b0;
        end else begin
          attn_q[i] <= set_i | (attn_q[i] & ~clr_i);
        end
      end
    end
  endgenerate

  // file status bus
  always @* begin
    fs = 8'h00;
    if (ty_disk) begin
      fs[`MDFA_BIT(0)] = dev_ready;
      fs[`MDFA_BIT(1)] = dev_online;
      fs[`MDFA_BIT(2)] = dev_unsafe;
      fs[`MDFA_BIT(4)] = dev_online;
      fs[`MDFA_BIT(5)] = (head_q == `MDFA_HEAD_EOC_A) |
                         (head_q == `MDFA_HEAD_EOC_B);
      fs[`MDFA_BIT(7)] = seek_inc_q;
    end else if (ty_strip) begin
      fs[`MDFA_BIT(0)] = drive_ready;
      fs[`MDFA_BIT(1)] = drive_operative;
      fs[`MDFA_BIT(4)] = strip_rdy_q;
      fs[`MDFA_BIT(5)] = ~invalid_addr;
      fs[`MDFA_BIT(6)] = auto_rst_q;
    end else if (ty_ldisk) begin
      fs[`MDFA_BIT(0)] = access_ready;
      fs[`MDFA_BIT(1)] = access_operative;
      fs[`MDFA_BIT(4)] = dev_online;
    end else if (ty_drum) begin
      fs[`MDFA_BIT(4)] = drum_online;
    end
  end

  // interface status and online bits
  always @* begin
    is_bits = 8'h00;
    is_bits[`MDFA_BIT(2)] = ty_drum ? drum_online : ~unsafe_q;
    if (ty_disk) begin
      is_bits[`MDFA_BIT(7)] = |attn_q;
    end else begin
      is_bits[`MDFA_BIT(6)] = |attn_q;
    end
    ie_bits = 8'h00;
    if (!sel_ok) begin
      ie_bits[`MDFA_BIT(3)] = 1'b1;
      ie_bits[`MDFA_BIT(5)] = 1'b1;
      ie_bits[`MDFA_BIT(6)] = 1'b1;
    end else if (ty_disk) begin
      ie_bits[`MDFA_BIT(7)] = 1'b1;
    end else if (ty_strip) begin
      ie_bits[`MDFA_BIT(6)] = 1'b1;
    end else if (ty_ldisk) begin
      ie_bits[`MDFA_BIT(5)] = 1'b1;
    end else begin
      ie_bits[`MDFA_BIT(3)] = 1'b1;
      ie_bits[`MDFA_BIT(6)] = 1'b1;
    end
  end

  // alternate source onto the unit input
  always @* begin
    if (altsrc_q == `MDFA_ALT_ATTN) begin
      alu_in = attn_q;
    end else if (altsrc_q == `MDFA_ALT_STATUS) begin
      alu_in = fs;
    end else if (altsrc_q == `MDFA_ALT_OLDADDR) begin
      alu_in = ty_disk ? cyl_position : head_q;
    end else if (altsrc_q == `MDFA_ALT_IFACE) begin
      alu_in = is_bits;
    end else begin
      alu_in = 8'h00;
    end
  end

  // read mux
  wire up_page = (uprog_q[11:8] >= `MDFA_UP_PAGE_LO) &
                 (uprog_q[11:8] <= `MDFA_UP_PAGE_HI);
  always @* begin
    hit  = 1'b1;
    rd_d = 32'h0000_0000;
    if (paddr == `MDFA_OFF_FT) begin
      rd_d[7:0] = ft_q;
    end else if (paddr == `MDFA_OFF_FC) begin
      rd_d[7:0] = fc_q;
    end else if (paddr == `MDFA_OFF_MODSEL) begin
      rd_d[3:0] = modsel_q;
    end else if (paddr == `MDFA_OFF_ALTSRC) begin
      rd_d[3:0] = altsrc_q;
    end else if (paddr == `MDFA_OFF_ALUIN) begin
      rd_d[7:0] = alu_in;
    end else if (paddr == `MDFA_OFF_IE) begin
      rd_d[7:0] = ie_bits;
    end else if (paddr == `MDFA_OFF_CMD) begin
      rd_d[2:0] = cmd_st_q;
    end else if (paddr == `MDFA_OFF_UPROG) begin
      rd_d[12:0] = {up_page & uprog_q[`MDFA_UP_GATE_BIT], uprog_q};
    end else if (paddr == `MDFA_OFF_HEAD) begin
      rd_d[7:0] = head_q;
    end else begin
      hit = 1'b0;
    end
  end

  // registers and sticky flags
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata      <= 32'h0000_0000;
      ft_q        <= `MDFA_RST_FT;
      fc_q        <= `MDFA_RST_FC;
      modsel_q    <= `MDFA_RST_MODSEL;
      altsrc_q    <= `MDFA_RST_ALTSRC;
      uprog_q     <= `MDFA_RST_UPROG;
      head_q      <= `MDFA_RST_HEAD;
      cmd_st_q    <= 3'b000;
      seek_inc_q  <= 1'b0;
      auto_rst_q  <= 1'b0;
      strip_rdy_q <= 1'b0;
      wr_req_q    <= 1'b0;
      lead_ok_q   <= 1'b0;
    end else begin
      if (setup) begin
        prdata <= rd_d;
      end
      if (wr_ft) begin
        ft_q <= pwdata[7:0];
      end
      if (wr_fc) begin
        fc_q <= fc_new;
      end
      if (wr_ms) begin
        modsel_q <= pwdata[3:0];
      end
      if (wr & (paddr == `MDFA_OFF_ALTSRC)) begin
        altsrc_q <= pwdata[3:0];
      end
      if (wr & (paddr == `MDFA_OFF_UPROG)) begin
        uprog_q <= pwdata[11:0];
      end
      if (wr & (paddr == `MDFA_OFF_HEAD)) begin
        head_q <= pwdata[7:0];
      end
      // status bits: rejected, no-operation, accepted
      if (wr_cm) begin
        if (ty_drum & (pwdata[1:0] == `MDFA_CMD_SCAN)) begin
          cmd_st_q <= 3'b001;
        end else if (ty_drum & (pwdata[1:0] != `MDFA_CMD_OTHER)) begin
          cmd_st_q <= 3'b010;
        end else begin
          cmd_st_q <= 3'b100;
        end
      end
      seek_inc_q  <= seek_done | (seek_inc_q & ~(fc2_p | wr_ms));
      auto_rst_q  <= idle_done | (auto_rst_q & ~strip_addr);
      strip_rdy_q <= (clutch_picked & early_index) |
                     (strip_rdy_q & clutch_picked);
      wr_req_q    <= wr_req_d;
      lead_ok_q   <= wr_req_d & (lead_done | lead_ok_q);
    end
  end

  // device lines, registered
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      write_gate    <= 1'b0;
      erase_gate    <= 1'b0;
      write_status  <= 1'b0;
      read_gate     <= 1'b0;
      head_select   <= 1'b0;
      rtz_pulse     <= 1'b0;
      seek_start    <= 1'b0;
      strip_restore <= 1'b0;
      drum_select   <= 1'b0;
      strip_select  <= 1'b0;
      uprog_gate_c  <= 1'b0;
    end else begin
      if (ty_strip) begin
        write_gate   <= wr_req_d & lead_ok_q & ~lead_run & ~unsafe_q;
        write_status <= wr_req_d & ~unsafe_q;
        erase_gate   <= 1'b0;
      end else begin
        write_gate   <= wr_req_d & ~unsafe_q;
        write_status <= 1'b0;
        // wr_req_q bridges the cycle before the hold timer is loaded
        erase_gate   <= (ty_disk | ty_ldisk) &
                        (wr_req_d | wr_req_q | hold_run);
      end
      read_gate     <= ctl_tag & fc_q[`MDFA_BIT(1)];
      head_select   <= ctl_tag & fc_q[`MDFA_BIT(5)] &
                       ~(ty_strip & unsafe_q);
      rtz_pulse     <= fc6_p & ty_disk;
      seek_start    <= fc2_p & (ty_disk | ty_strip);
      // drum treats the restore bit as no-operation
      strip_restore <= (fc6_p & ty_strip) | idle_done;
      drum_select   <= ft_q[`MDFA_BIT(6)] & drum_online;
      strip_select  <= ft_q[`MDFA_BIT(6)] & strip_online;
      uprog_gate_c  <= uprog_q[`MDFA_UP_GATE_BIT] & up_page;
    end
  end
endmodule

// *** testbench/mdfa_ctrl_assertions.sv ***
// mdfa_ctrl_assertions.sv: port timing checks of the attachment control.
// assumes one pclk domain with presetn as its asynchronous reset.
`timescale 1ns/100ps
module mdfa_ctrl_chk (
  // clock and reset
  input logic        pclk,
  input logic        presetn,
  // apb
  input logic        psel,
  input logic        penable,
  input logic        pwrite,
  input logic [7:0]  paddr,
  input logic [31:0] pwdata,
  input logic        pslverr,
  // device lines
  input logic        write_gate,
  input logic        erase_gate,
  input logic        write_status,
  input logic        rtz_pulse,
  input logic        strip_restore,
  input logic        drum_select,
  input logic        drum_online,
  input logic        uprog_gate_c
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  logic [8:0] lead_q;
  logic       page_q;
  // saturates so a long write status never wraps to a short lead
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lead_q <= 9'h000;
      page_q <= 1'b0;
    end else begin
      lead_q <= !write_status ? 9'h000 : lead_q + {8'h00, ~&lead_q};
      if (psel && penable && pwrite && paddr == 8'h1c)
        page_q <= pwdata[11] && pwdata[10:8] < 3'h3;
    end
  end
  a_erase_hold: assert property (
    $fell(write_gate) && erase_gate |-> erase_gate [*8])
    else $error("erase dropped right after write gate");
  a_wstat_lead: assert property (
    $rose(write_gate) && write_status |-> lead_q >= 9'd199)
    else $error("write gate rose too soon after write status");
  a_gate_follows: assert property (
    $fell(write_status) |-> ##[0:1] !write_gate)
    else $error("write gate stayed up without write status");
  a_rtz_pulse: assert property (
    rtz_pulse |=> !rtz_pulse)
    else $error("return to zero longer than one cycle");
  a_restore_pulse: assert property (
    strip_restore |=> !strip_restore)
    else $error("strip restore longer than one cycle");
  a_drum_online: assert property (
    drum_select |-> $past(drum_online))
    else $error("drum selected while drum offline");
  a_uprog_page: assert property (
    psel && penable && pwrite && paddr == 8'h1c |-> ##2 uprog_gate_c == page_q)
    else $error("routine gate does not follow page");
  a_unmapped_err: assert property (
    psel && penable && paddr > 8'h20 |-> pslverr)
    else $error("unmapped access without error");
endmodule

bind mdfa_ctrl mdfa_ctrl_chk u_chk (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pslverr,
  .write_gate, .erase_gate, .write_status, .rtz_pulse, .strip_restore,
  .drum_select, .drum_online, .uprog_gate_c
);

// *** testbench/mdfa_dev_model.sv ***
// mdfa_dev_model.sv: behavioural disk and strip unit behind the block.
// assumes its control lines change only at pclk edges.
`timescale 1ns/100ps
module mdfa_dev_model (
  // clock and controls
  input  logic       pclk,
  input  logic       seek_start,
  input  logic       rtz_pulse,
  input  logic       strip_select,
  input  int         seek_lat,
  // device lines
  output logic       seek_complete = 1'b1,
  output logic [7:0] cyl_position = 8'h05,
  output logic       clutch_picked = 1'b0,
  output logic       early_index = 1'b0
);
  int sk = 0;
  int st = 0;
  always @(posedge pclk) begin
    st <= strip_select ? st + 1 : 0;
    clutch_picked <= strip_select && st > 3;
    early_index <= strip_select && st > 7;
    if (seek_start) begin
      seek_complete <= 1'b0;
      sk <= seek_lat;
    end else if (sk > 1) begin
      sk <= sk - 1;
    end else if (sk == 1) begin
      sk <= 0;
      seek_complete <= 1'b1;
      cyl_position <= cyl_position + 8'h01;
    end
    // access back at cylinder zero
    if (rtz_pulse)
      cyl_position <= 8'h00;
  end
endmodule

// *** testbench/mdfa_ctrl_bench.sv ***
// mdfa_ctrl_bench.sv: self-checking bench of the attachment control.
// assumes the rtl files and the device model are compiled before it.
`timescale 1ns/100ps
module mdfa_ctrl_bench;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, se;
  logic [7:0] paddr = 0, mod_present = 8'hff, attention_in = 0;
  logic [31:0] pwdata = 0, prdata, r;
  logic [15:0] mod_type = 0, lf = 16'd55510;
  logic [6:0] mon = 7'h7f;
  logic dev_unsafe = 0, invalid_addr = 0, drum_online = 0;
  logic pready, pslverr, seek_complete, clutch_picked, early_index;
  logic [7:0] cyl_position;
  logic write_gate, erase_gate, write_status, head_select, rtz_pulse;
  logic seek_start, strip_restore, drum_select, strip_select, uprog_gate_c;
  int n_errors = 0, checked = 0, seek_lat = 10, n;
  int ie_t[4] = '{1, 2, 4, 18};
  int cmd_t[4] = '{4, 1, 2, 2};
  int hold[3] = '{2304, 0, 1600};
  mdfa_ctrl #(.SEEK_TO_CYC(26'd50), .AUTO_RST_CYC(26'd400)) DUT (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .mod_present, .mod_type, .attention_in,
    .dev_ready(1'b1), .dev_online(1'b1), .dev_unsafe, .seek_complete,
    .cyl_position, .access_ready(mon[3]), .access_operative(mon[4]),
    .read_safe(mon[5]), .write_safe(mon[6]), .strip_online(1'b1),
    .drive_ready(mon[0]), .drive_operative(mon[1]), .rw_safe(mon[2]),
    .invalid_addr, .clutch_picked, .early_index, .drum_online,
    .write_gate, .erase_gate, .write_status, .read_gate(), .head_select,
    .rtz_pulse, .seek_start, .strip_restore, .drum_select, .strip_select,
    .uprog_gate_c);
  mdfa_dev_model u_dev (.pclk, .seek_start, .rtz_pulse, .strip_select,
    .seek_lat, .seek_complete, .cyl_position, .clutch_picked, .early_index);
  function automatic logic [15:0] lfsr(logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic close_out;
    if (n_errors == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    checked++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  // counts are taken at edges, so a few cycles of slack above the least
  task automatic near(string nm, int e, int g);
    checked++;
    if (g < e || g > e + 3) begin
      n_errors++;
      $display("mismatch %s expected %0d seen %0d", nm, e, g);
    end
  endtask
  task automatic apb(logic [7:0] a, logic w, logic [31:0] d);
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    se = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    apb(a, 1, d);
  endtask
  task automatic rdm(logic [7:0] a, logic [31:0] m, logic [31:0] e);
    apb(a, 0, 0);
    chk($sformatf("read_%h", a), e, r & m);
  endtask
  initial begin
    forever #12.5 pclk = ~pclk;
  end
  initial begin
    repeat (20000) @(posedge pclk);
    n_errors++;
    close_out;
  end
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1;
    rdm(8'h14, 32'hff, 32'h16);
    apb(8'h24, 0, 0);
    chk("slverr", 1, se);
    chk("unmapped", 0, r);
    for (int t = 0; t < 4; t++) begin
      mod_type <= {8{t[1:0]}};
      wr(8'h08, 8);
      rdm(8'h14, 32'hff, ie_t[t]);
    end
    mod_present <= 8'hfe;
    wr(8'h08, 8);
    rdm(8'h14, 32'hff, 32'h16);
    mod_present <= 8'hff;
    for (int t = 0; t < 3; t++) begin
      mod_type <= {8{t[1:0]}};
      wr(8'h08, 8);
      wr(8'h00, 0);
      wr(8'h04, 32'h8c);
      n = 0;
      while (write_gate !== 1'b1 && n < 400) begin
        @(posedge pclk);
        n += (write_status === 1'b1);
      end
      if (t == 1) near("lead", 200, n);
      chk("erase", t != 1, erase_gate);
      if (t == 1) begin
        chk("head", 1, head_select);
        mon <= 7'h7e;
        repeat (3) @(posedge pclk);
        chk("unsafe", 0, {write_gate, write_status, head_select});
        mon <= 7'h7f;
      end
      wr(8'h04, 0);
      n = 0;
      while (erase_gate === 1'b1 && n < 4000) begin
        @(posedge pclk);
        n++;
      end
      if (t != 1) near("erase_hold", hold[t], n);
    end
    wr(8'h0c, 32'hf);
    for (int i = 0; i < 7; i++) begin
      mod_type <= {8{(i < 3) ? 2'd1 : 2'd2}};
      wr(8'h08, 8);
      wr(8'h00, 0);
      mon <= ~(7'h1 << i);
      rdm(8'h10, 32'h20, 0);
      mon <= 7'h7f;
      rdm(8'h10, 32'h20, 0);
      wr(8'h00, 0);
      rdm(8'h10, 32'h20, 32'h20);
    end
    mod_type <= 16'hffff;
    drum_online <= 1;
    wr(8'h08, 8);
    wr(8'h00, 32'h02);
    repeat (2) @(posedge pclk);
    chk("drum_sel", 1, drum_select);
    rdm(8'h10, 32'h22, 32'h20);
    for (int c = 0; c < 4; c++) begin
      wr(8'h18, c);
      rdm(8'h18, 32'h7, cmd_t[c]);
    end
    wr(8'h00, 32'h01);
    rdm(8'h10, 32'h22, 32'h22);
    drum_online <= 0;
    wr(8'h08, 8);
    rdm(8'h10, 32'h22, 0);
    mod_type <= 0;
    attention_in <= 8'h10;
    wr(8'h08, 8);
    rdm(8'h10, 32'h01, 1);
    attention_in <= 0;
    wr(8'h0c, 32'hd);
    for (int h = 9; h < 13; h++) begin
      wr(8'h20, h);
      rdm(8'h10, 32'h04, (h == 10 || h == 11) ? 4 : 0);
    end
    wr(8'h00, 0);
    for (int s = 0; s < 2; s++) begin
      seek_lat = s ? 1000 : 10;
      wr(8'h04, 0);
      wr(8'h04, 32'h20);
      repeat (60) @(posedge pclk);
      rdm(8'h10, 32'h01, s);
    end
    wr(8'h04, 32'h02);
    wr(8'h0c, 32'he);
    rdm(8'h10, 32'hff, 0);
    mod_type <= 16'h5555;
    wr(8'h08, 8);
    attention_in <= 8'h01;
    wr(8'h00, 0);
    attention_in <= 0;
    wr(8'h0c, 32'hc);
    rdm(8'h10, 32'h01, 1);
    wr(8'h04, 32'h40);
    rdm(8'h10, 32'h01, 0);
    wr(8'h00, 32'h02);
    wr(8'h0c, 32'hd);
    invalid_addr <= 1;
    mon <= 7'h7d;
    rdm(8'h10, 32'h44, 0);
    invalid_addr <= 0;
    mon <= 7'h7f;
    rdm(8'h10, 32'h44, 32'h44);
    repeat (420) @(posedge pclk);
    rdm(8'h10, 32'h0a, 32'h0a);
    for (int k = 0; k < 8; k++) begin
      lf = lfsr(lf);
      wr(8'h1c, lf[11:0]);
      rdm(8'h1c, 32'h1fff, {lf[11] && lf[10:8] < 3, lf[11:0]});
    end
    close_out;
  end
endmodule
